// ### design/frmc_defines.svh
// constants of the fifo reset and mode configuration block
// assumes inclusion by bare name from the fifo core module
`ifndef FRMC_DEFINES_SVH
`define FRMC_DEFINES_SVH

// ----------------------------------------------------------------------------
// feature configuration register fields
// ----------------------------------------------------------------------------
`define FRMC_CFG_WIDTH      12
`define FRMC_CFG_PTR_RST    0
`define FRMC_CFG_AE_SYNC    1
`define FRMC_CFG_HF_LO      2
`define FRMC_CFG_HF_HI      3
`define FRMC_CFG_AF_SYNC    4
`define FRMC_CFG_OE_GATE    5
`define FRMC_CFG_ENH_MASK   12'h03F
`define FRMC_CFG_RESET      12'h000

// ----------------------------------------------------------------------------
// data and offset layout, reset values
// ----------------------------------------------------------------------------
`define FRMC_DATA_WIDTH     18
`define FRMC_DEPTH          512
`define FRMC_OFFSET_WIDTH   12
`define FRMC_OFFSET_DIV     8
`define FRMC_DATA_RESET     18'h00000

`endif

// ### design/frmc_fifo.sv
// fifo core with reset defaults, mode select and feature configuration
// assumes write and read parties share ref_clk; the data bus wire is
// resolved outside from read_data_oe
`timescale 1ns/1ps
`include "frmc_defines.svh"

// Behaviour
// - synchronous almost-full option clocks flag on write
// - bit 05 low: enable only gates outputs
// - bit 05 high: disabled outputs freeze read pointer
// - bits 06-11 reserved, reset zero
// - compatible mode hides configuration register
// - reset sets bits 00-05 from mode select
// - reset input acts asynchronously
// - reset returns both pointers to zero
// - reset shows empty on all five flags
// - reset loads offsets with depth/8 minus one
// - data outputs low after reset until first read
// - enhanced features individually rewritable after reset
// - enhanced mode repurposes expansion inputs as enables
// - enhanced mode expansion output duplicates empty
// - duplicate empty lags one extra cycle
// - enhanced read needs both enables, maybe output enable
module frmc_fifo #(
   parameter int WIDTH = `FRMC_DATA_WIDTH,
   parameter int DEPTH = `FRMC_DEPTH
) (
   input  wire logic             ref_clk,
   input  wire logic             reset,
   input  wire logic             reset_input_n,
   input  wire logic             enhanced_mode_select_n,
   input  wire logic             program_register_select_n,
   input  wire logic             write_en_n,
   input  wire logic             write_expand_in_or_second_write_enable,
   input  wire logic [WIDTH-1:0] write_data_in,
   input  wire logic             read_en_n,
   input  wire logic             read_expand_in_or_second_read_enable,
   input  wire logic             output_enable_n,
   output logic      [WIDTH-1:0] read_data_out,
   output logic                  read_data_oe,
   output logic                  full_flag_n,
   output logic                  almost_full_flag_n,
   output logic                  half_full_flag_n,
   output logic                  almost_empty_flag_n,
   output logic                  empty_flag_n,
   output logic                  read_expand_out_or_dup_empty_flag,
   output frmc_pkg::frmc_sel_e   progWriteSel,
   output logic [`FRMC_CFG_WIDTH-1:0] featureConfig
);
   import frmc_pkg::*;

   // ---------------------------------------------------------------------------
   // constants
   // ---------------------------------------------------------------------------
   localparam int AW = $clog2(DEPTH);
   localparam int CW = AW + 1;
   localparam int OW = `FRMC_OFFSET_WIDTH;
   localparam logic [OW-1:0] OFFSET_RESET =
      OW'(DEPTH / `FRMC_OFFSET_DIV - 1);
   localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
   localparam logic [CW-1:0] HALF_C  = CW'(DEPTH / 2);

   // ---------------------------------------------------------------------------
   // state
   // ---------------------------------------------------------------------------
   logic [AW-1:0]     wrPtr, next_wrPtr;          // write address
   logic [AW-1:0]     rdPtr, next_rdPtr;          // read address
   logic [CW-1:0]     fill, next_fill;            // words held
   logic [OW-1:0]     aeOffset, next_aeOffset;    // almost-empty offset
   logic [OW-1:0]     afOffset, next_afOffset;    // almost-full offset
   logic [`FRMC_CFG_WIDTH-1:0] next_featureConfig;
   frmc_sel_e         next_progWriteSel;
   frmc_sel_e         progReadSel, next_progReadSel;
   logic              defaultsDue, next_defaultsDue; // mode not yet taken
   logic              enhRoles, next_enhRoles;    // pins in enhanced role
   logic              showProg, next_showProg;    // output shows prog word
   logic [WIDTH-1:0]  progWord, next_progWord;    // programmable read word
   logic              inReset;                    // synchronous reset term

   // flag pipeline: raw registered view and one extra sync stage
   logic [4:0]        flagRaw, next_flagRaw;
   logic [4:0]        flagSync;
   logic              dupEmpty;

   // ---------------------------------------------------------------------------
   // request qualification
   // ---------------------------------------------------------------------------
   logic compatMode, cfgVisible, enOk2W, enOk2R, oeOk;
   logic fifoWrite, fifoRead, progWrite, progRead;

   assign inReset    = reset;
   // compatible mode hides the configuration register from the sequence
   assign compatMode = !enhRoles &&
                       ((featureConfig & `FRMC_CFG_ENH_MASK) == '0);
   assign cfgVisible = !compatMode;
   assign enOk2W = !enhRoles || write_expand_in_or_second_write_enable;
   assign enOk2R = !enhRoles || read_expand_in_or_second_read_enable;
   // output enable gates reads only when bit 05 is set
   assign oeOk = !featureConfig[`FRMC_CFG_OE_GATE] || !output_enable_n;
   assign fifoWrite = !defaultsDue && program_register_select_n &&
                      !write_en_n && enOk2W && fill != DEPTH_C;
   assign fifoRead  = !defaultsDue && program_register_select_n &&
                      !read_en_n && enOk2R && oeOk && fill != '0;
   assign progWrite = !defaultsDue && !program_register_select_n &&
                      !write_en_n;
   assign progRead  = !defaultsDue && !program_register_select_n &&
                      !read_en_n && oeOk;

   // advance a selector through the register sequence
   function automatic frmc_sel_e nextSel(input frmc_sel_e s,
                                         input logic     withCfg);
      frmc_sel_e r;
      r = FRMC_SEL_AE;
      case (s)
         FRMC_SEL_AE:  r = FRMC_SEL_AF;
         FRMC_SEL_AF:  r = withCfg ? FRMC_SEL_CFG : FRMC_SEL_AE;
         default:      r = FRMC_SEL_AE;
      endcase
      return r;
   endfunction

   // ---------------------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------------------
   // one combinational view of the core registers; the clocked process copies
   // it outside its two reset branches, which load the defaults themselves
   always_comb begin
      next_wrPtr         = wrPtr;
      next_rdPtr         = rdPtr;
      next_fill          = fill;
      next_aeOffset      = aeOffset;
      next_afOffset      = afOffset;
      next_featureConfig = featureConfig;
      next_progWriteSel  = progWriteSel;
      next_progReadSel   = progReadSel;
      next_defaultsDue   = 1'b0;
      next_enhRoles      = enhRoles;
      next_showProg      = showProg;
      next_progWord      = progWord;
      // mode select is taken at the first edge after reset release
      if (defaultsDue) begin
         next_enhRoles = !enhanced_mode_select_n;
         if (!enhanced_mode_select_n) begin
            next_featureConfig = `FRMC_CFG_RESET |
                                 `FRMC_CFG_ENH_MASK;
         end else begin
            next_featureConfig = `FRMC_CFG_RESET;
         end
      end
      // fifo data path
      if (fifoWrite) begin
         next_wrPtr = AW'(wrPtr + 1'b1);
      end
      if (fifoRead) begin
         next_rdPtr    = AW'(rdPtr + 1'b1);
         next_showProg = 1'b0;
      end
      next_fill = CW'(fill + CW'(fifoWrite) - CW'(fifoRead));
      // programmable register writes, upper bits stored as given
      if (progWrite) begin
         case (progWriteSel)
            FRMC_SEL_AE:  next_aeOffset = write_data_in[OW-1:0];
            FRMC_SEL_AF:  next_afOffset = write_data_in[OW-1:0];
            default: begin
               // each feature bit rewritable on its own
               next_featureConfig = write_data_in[`FRMC_CFG_WIDTH-1:0];
            end
         endcase
         next_progWriteSel = nextSel(progWriteSel, cfgVisible);
      end
      if (progRead) begin
         case (progReadSel)
            FRMC_SEL_AE:  next_progWord = WIDTH'(aeOffset);
            FRMC_SEL_AF:  next_progWord = WIDTH'(afOffset);
            default:      next_progWord = WIDTH'(featureConfig);
         endcase
         next_showProg    = 1'b1;
         next_progReadSel = nextSel(progReadSel, cfgVisible);
      end
      // bit 00 set: releasing the select restarts the sequence
      if (featureConfig[`FRMC_CFG_PTR_RST] && program_register_select_n) begin
         next_progWriteSel = FRMC_SEL_AE;
         next_progReadSel  = FRMC_SEL_AE;
      end
   end

   // ---------------------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------------------
   // the pin reset clears without a clock edge; the system reset waits for one
   always_ff @(posedge ref_clk or negedge reset_input_n) begin
      if (!reset_input_n) begin
         wrPtr         <= '0;
         rdPtr         <= '0;
         fill          <= '0;
         aeOffset      <= OFFSET_RESET;
         afOffset      <= OFFSET_RESET;
         featureConfig <= `FRMC_CFG_RESET;
         progWriteSel  <= FRMC_SEL_AE;
         progReadSel   <= FRMC_SEL_AE;
         defaultsDue   <= 1'b1;
         enhRoles      <= 1'b0;
         showProg      <= 1'b1;
         progWord      <= `FRMC_DATA_RESET;
      end else if (inReset) begin
         wrPtr         <= '0;
         rdPtr         <= '0;
         fill          <= '0;
         aeOffset      <= OFFSET_RESET;
         afOffset      <= OFFSET_RESET;
         featureConfig <= `FRMC_CFG_RESET;
         progWriteSel  <= FRMC_SEL_AE;
         progReadSel   <= FRMC_SEL_AE;
         defaultsDue   <= 1'b1;
         enhRoles      <= 1'b0;
         showProg      <= 1'b1;
         progWord      <= `FRMC_DATA_RESET;
      end else begin
         wrPtr         <= next_wrPtr;
         rdPtr         <= next_rdPtr;
         fill          <= next_fill;
         aeOffset      <= next_aeOffset;
         afOffset      <= next_afOffset;
         featureConfig <= next_featureConfig;
         progWriteSel  <= next_progWriteSel;
         progReadSel   <= next_progReadSel;
         defaultsDue   <= next_defaultsDue;
         enhRoles      <= next_enhRoles;
         showProg      <= next_showProg;
         progWord      <= next_progWord;
      end
   end

   // ---------------------------------------------------------------------------
   // flags: {full, almost full, half, almost empty, empty}, active low
   // ---------------------------------------------------------------------------
   // compare against the post-update fill so raw flags track each edge
   always_comb begin
      next_flagRaw[4] = !(next_fill == DEPTH_C);
      next_flagRaw[3] = !(next_fill >= CW'(DEPTH_C - CW'(afOffset)));
      next_flagRaw[2] = !(next_fill > HALF_C);
      next_flagRaw[1] = !(next_fill <= CW'(aeOffset));
      next_flagRaw[0] = !(next_fill == '0);
   end

   always_ff @(posedge ref_clk or negedge reset_input_n) begin
      if (!reset_input_n) begin
         flagRaw  <= 5'h1C;
         flagSync <= 5'h1C;
         dupEmpty <= 1'b0;
      end else if (inReset) begin
         flagRaw  <= 5'h1C;
         flagSync <= 5'h1C;
         dupEmpty <= 1'b0;
      end else begin
         flagRaw  <= next_flagRaw;
         flagSync <= flagRaw;          // one extra cycle when synchronous
         dupEmpty <= empty_flag_n;
      end
   end

   // synchronous option adds one edge of delay, trading latency for a flag
   // that moves only with its own port's edge
   assign full_flag_n        = flagRaw[4];
   assign almost_full_flag_n = featureConfig[`FRMC_CFG_AF_SYNC] ?
                               flagSync[3] : flagRaw[3];
   assign half_full_flag_n   = (featureConfig[`FRMC_CFG_HF_HI] ||
                                featureConfig[`FRMC_CFG_HF_LO]) ?
                               flagSync[2] : flagRaw[2];
   assign almost_empty_flag_n = featureConfig[`FRMC_CFG_AE_SYNC] ?
                               flagSync[1] : flagRaw[1];
   assign empty_flag_n       = flagRaw[0];
   // expansion output idles high outside enhanced mode
   assign read_expand_out_or_dup_empty_flag = enhRoles ? dupEmpty : 1'b1;

   // ---------------------------------------------------------------------------
   // data array and output drive
   // ---------------------------------------------------------------------------
   logic [WIDTH-1:0] memData;

   frmc_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_mem (
      .clk    (ref_clk),
      .clr    (inReset || defaultsDue),
      .wrEn   (fifoWrite),
      .wrAddr (wrPtr),
      .wrData (write_data_in),
      .rdEn   (fifoRead),
      .rdAddr (rdPtr),
      .rdData (memData)
   );

   // output enable steers the drive; with bit 05 set it also holds the data by blocking reads
   assign read_data_out = showProg ? progWord : memData;
   assign read_data_oe  = !output_enable_n;

   // ---------------------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------------------
   a_gate_holds_ptr: assert property (@(posedge ref_clk)
      disable iff (reset || !reset_input_n)
      featureConfig[5] && output_enable_n |=> $stable(rdPtr))
      else $error("read pointer moved while outputs gated");
   a_oe_free_read: assert property (@(posedge ref_clk)
      disable iff (reset || !reset_input_n)
      !featureConfig[5] && output_enable_n && !read_en_n && enOk2R &&
      program_register_select_n && !defaultsDue && fill != '0
      |=> rdPtr == AW'($past(rdPtr) + 1'b1))
      else $error("read pointer did not advance with outputs off");
   a_reserved_zero: assert property (@(posedge ref_clk)
      disable iff (reset || !reset_input_n)
      defaultsDue |=> featureConfig[11:6] == '0)
      else $error("reserved configuration bits not zero at reset");
   a_mode_defaults: assert property (@(posedge ref_clk)
      disable iff (reset || !reset_input_n)
      defaultsDue |=> featureConfig[5:0] ==
         ($past(enhanced_mode_select_n) ? 6'h00 : 6'h3F))
      else $error("configuration defaults disagree with mode select");
   a_reset_state: assert property (@(posedge ref_clk)
      inReset |=> wrPtr == '0 && rdPtr == '0 && fill == '0)
      else $error("pointers not cleared by reset");
   a_empty_flags: assert property (@(posedge ref_clk)
      inReset |=> full_flag_n && half_full_flag_n && !empty_flag_n &&
                  flagRaw[3] && !flagRaw[1])
      else $error("flags do not show empty after reset");
   a_offset_load: assert property (@(posedge ref_clk)
      inReset |=> aeOffset == OFFSET_RESET && afOffset == OFFSET_RESET)
      else $error("offsets not loaded with default");
   a_quiet_output: assert property (@(posedge ref_clk)
      inReset ##1 (!fifoRead && !progRead) [*3] |=> read_data_out == '0)
      else $error("data outputs not low after reset");
   a_dup_empty_lag: assert property (@(posedge ref_clk)
      disable iff (reset || !reset_input_n)
      enhRoles && $past(enhRoles) |->
         read_expand_out_or_dup_empty_flag == $past(empty_flag_n))
      else $error("duplicate empty not one cycle late");
   a_second_enable: assert property (@(posedge ref_clk)
      disable iff (reset || !reset_input_n)
      enhRoles && !read_expand_in_or_second_read_enable |-> !fifoRead)
      else $error("read taken without second read enable");
   a_sync_af: assert property (@(posedge ref_clk)
      disable iff (reset || !reset_input_n)
      featureConfig[4] && $past(featureConfig[4]) |->
         almost_full_flag_n == $past(flagRaw[3]))
      else $error("synchronous almost-full not delayed one edge");
endmodule

// ### design/frmc_mem.sv
// storage array of the fifo with a registered read port
// assumes one clock for both ports; clr empties the read register
`timescale 1ns/1ps
module frmc_mem #(
   parameter int WIDTH = 18,
   parameter int DEPTH = 512,
   parameter int AW    = $clog2(DEPTH)
) (
   input  wire logic             clk,
   input  wire logic             clr,
   input  wire logic             wrEn,
   input  wire logic [AW-1:0]    wrAddr,
   input  wire logic [WIDTH-1:0] wrData,
   input  wire logic             rdEn,
   input  wire logic [AW-1:0]    rdAddr,
   output logic      [WIDTH-1:0] rdData
);
   // ---------------------------------------------------------------------------
   // array and read register
   // ---------------------------------------------------------------------------
   logic [WIDTH-1:0] store [DEPTH];   // no reset: contents are don't-care

   // write port
   always_ff @(posedge clk) begin
      if (wrEn) begin
         store[wrAddr] <= wrData;
      end
   end

   // read register holds its word when no read is made
   always_ff @(posedge clk) begin
      if (clr) begin
         rdData <= '0;
      end else if (rdEn) begin
         rdData <= store[rdAddr];
      end
   end
endmodule

// ### design/frmc_pkg.sv
// types shared by the fifo reset and mode configuration design
// assumes the defines header sits beside it
package frmc_pkg;
   // ---------------------------------------------------------------------------
   // programmable register selector, one-hot
   // ---------------------------------------------------------------------------
   typedef enum logic [2:0] {
      FRMC_SEL_AE  = 3'b001,   // almost-empty offset
      FRMC_SEL_AF  = 3'b010,   // almost-full offset
      FRMC_SEL_CFG = 3'b100    // feature configuration register
   } frmc_sel_e;
endpackage

// ### test/frmc_host_model.sv
// writing and reading parties on the fifo ports, driven through tasks
// assumes one ref_clk for both sides; signals change on falling edges, except the reset drop of async_low
`timescale 1ns/1ps
module frmc_host_model (
   input  wire logic        ref_clk,
   output logic             resetInN,
   output logic             modeSelN,
   output logic             progSelN,
   output logic             wrEnN,
   output logic             wrEn2,
   output logic [17:0]      wrData,
   output logic             rdEnN,
   output logic             rdEn2,
   output logic             outEnN
);
   // ------------------------------------------------------------------
   // idle levels; reset held from power-up until do_reset releases it
   // ------------------------------------------------------------------
   initial begin
      resetInN = 1'b0;
      modeSelN = 1'b1;
      progSelN = 1'b1;
      wrEnN    = 1'b1;
      wrEn2    = 1'b0;
      wrData   = 18'h00000;
      rdEnN    = 1'b1;
      rdEn2    = 1'b0;
      outEnN   = 1'b0;
   end
   // mode select is set only while reset is low, then left alone
   task automatic do_reset(input logic enh);
      @(negedge ref_clk);
      resetInN = 1'b0;
      modeSelN = !enh;
      repeat (10) @(negedge ref_clk);
      resetInN = 1'b1;
      repeat (2) @(negedge ref_clk);
   endtask
   // one write; register words carry zeros above bit 11
   task automatic put(input logic ld, input logic en2, input logic [17:0] w);
      @(negedge ref_clk);
      progSelN = ld;
      wrEn2    = en2;
      wrData   = ld ? w : {6'h00, w[11:0]};
      wrEnN    = 1'b0;
      @(negedge ref_clk);
      wrEnN    = 1'b1;
      // select left as it was: raising it with bit 00 set would restart
      // the register sequence between the words of one programming run
      wrData   = ~wrData; // released bus does not keep its value
   endtask
   // one read request with chosen output enable and second enable
   task automatic get(input logic ld, input logic oeN, input logic en2);
      @(negedge ref_clk);
      progSelN = ld;
      outEnN   = oeN;
      rdEn2    = en2;
      rdEnN    = 1'b0;
      @(negedge ref_clk);
      rdEnN    = 1'b1;
      progSelN = 1'b1;
   endtask
   // reset dropped between edges to show it does not wait for a clock
   task automatic async_low();
      @(negedge ref_clk);
      #2 resetInN = 1'b0;
      #1;
   endtask
endmodule

// ### test/tb_top.sv
// self-checking bench of the fifo reset and mode configuration block
// assumes the host model drives every pin except ref_clk and reset
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin errors++; \
   $display("Error t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_top;
   import frmc_pkg::*;
   localparam int          DEPTH = 512;
   localparam logic [17:0] OFS   = 18'(DEPTH / 8 - 1);
   logic        ref_clk, reset, rstN, modeN, ldN, wrN, wr2, rdN, rd2, oeN;
   logic [17:0] din, dout;
   logic        oe, ff, af, hf, ae, ef, dup, trk, lastEf;
   frmc_sel_e   sel;
   logic [11:0] cfg;
   int          errors, n_checks;
   frmc_host_model u_host (.ref_clk(ref_clk), .resetInN(rstN),
      .modeSelN(modeN), .progSelN(ldN), .wrEnN(wrN), .wrEn2(wr2),
      .wrData(din), .rdEnN(rdN), .rdEn2(rd2), .outEnN(oeN));
   frmc_fifo #(.DEPTH(DEPTH)) u_dut (.ref_clk(ref_clk), .reset(reset),
      .reset_input_n(rstN), .enhanced_mode_select_n(modeN),
      .program_register_select_n(ldN), .write_en_n(wrN),
      .write_expand_in_or_second_write_enable(wr2), .write_data_in(din),
      .read_en_n(rdN), .read_expand_in_or_second_read_enable(rd2),
      .output_enable_n(oeN), .read_data_out(dout), .read_data_oe(oe),
      .full_flag_n(ff), .almost_full_flag_n(af), .half_full_flag_n(hf),
      .almost_empty_flag_n(ae), .empty_flag_n(ef),
      .read_expand_out_or_dup_empty_flag(dup), .progWriteSel(sel),
      .featureConfig(cfg));
   // ------------------------------------------------------------------
   // 8 ns clock, duplicate empty watched one cycle behind the flag
   // ------------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   always @(negedge ref_clk) begin
      if (trk) `CHK(dup, lastEf)
      lastEf = ef;
   end
   task automatic results();
      if (errors == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // ------------------------------------------------------------------
   // main sequence: compatible defaults, enhanced gating, async reset
   // ------------------------------------------------------------------
   initial begin
      errors = 0;
      n_checks = 0;
      trk = 1'b0;
      lastEf = 1'b0;
      reset = 1'b1;
      repeat (10) @(negedge ref_clk);
      reset = 1'b0;
      u_host.do_reset(1'b0);
      `CHK(cfg, 12'h000)
      `CHK({ff, af, hf, ae, ef}, 5'b11100)
      `CHK(dout, 18'h00000)
      u_host.get(1'b0, 1'b0, 1'b0);
      `CHK(dout, OFS)
      u_host.get(1'b0, 1'b0, 1'b0);
      `CHK(dout, OFS)
      // third read wraps to the first offset: no visible config word
      u_host.get(1'b0, 1'b0, 1'b0);
      `CHK(dout, OFS)
      u_host.do_reset(1'b1);
      `CHK(cfg, 12'h03F)
      `CHK(cfg[11:6], 6'h00)
      trk = 1'b1;
      u_host.put(1'b1, 1'b1, 18'h2A5C3);
      u_host.put(1'b1, 1'b0, 18'h15A3C);
      u_host.put(1'b1, 1'b1, 18'h3C0F0);
      u_host.put(1'b1, 1'b1, 18'h0F1E2);
      repeat (2) @(negedge ref_clk);
      `CHK(ef, 1'b1)
      u_host.get(1'b1, 1'b1, 1'b1);
      `CHK(oe, 1'b0)
      u_host.get(1'b1, 1'b0, 1'b1);
      `CHK(dout, 18'h2A5C3)
      u_host.get(1'b1, 1'b0, 1'b0);
      `CHK(dout, 18'h2A5C3)
      u_host.get(1'b1, 1'b0, 1'b1);
      `CHK(dout, 18'h3C0F0)
      u_host.put(1'b0, 1'b1, OFS);
      u_host.put(1'b0, 1'b1, OFS);
      u_host.put(1'b0, 1'b1, 18'h0001F);
      `CHK(cfg, 12'h01F)
      // outputs off no longer stop the pointer
      u_host.get(1'b1, 1'b1, 1'b1);
      `CHK(oe, 1'b0)
      u_host.get(1'b1, 1'b0, 1'b0);
      `CHK(dout, 18'h0F1E2)
      `CHK(ef, 1'b0)
      u_host.put(1'b1, 1'b1, 18'h00777);
      repeat (2) @(negedge ref_clk);
      `CHK(ef, 1'b1)
      trk = 1'b0;
      u_host.async_low();
      `CHK(ef, 1'b0)
      `CHK(dout, 18'h00000)
      u_host.do_reset(1'b0);
      `CHK(cfg, 12'h000)
      `CHK({ff, af, hf, ae, ef}, 5'b11100)
      `CHK(dup, 1'b1)
      results();
   end
endmodule
